//--- rtl/qpc_phase_decoder.sv
// pin synchroniser and quadrature decoder for the two phase inputs
`timescale 1ns/100ps
module qpc_phase_decoder (
	// clocking
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// encoder pins
	input wire logic phase_a_input,
	input wire logic phase_b_input,
	// decoded events
	output logic a_rise, // phase a rising edge, one cycle
	output logic b_level, // synchronised phase b
	output logic quad_step, // one quadrature transition
	output logic quad_up // direction of that transition
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] meta; // first synchroniser stage, a then b
		logic [1:0] sync; // second stage
		logic [1:0] prev; // previous synchronised value
	} qpc_dec_state_t;

	qpc_dec_state_t st; // registered state
	qpc_dec_state_t next_st; // next state

	// shift the pins through two flops, then one more for edges
	always_comb begin
		next_st = st;
		next_st.meta = {phase_a_input, phase_b_input};
		next_st.sync = st.meta;
		next_st.prev = st.sync;
	end

	// whole struct frozen while ce is low
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// decoding, only from synchronised stages
	// ----------------------------------------------------------------
	assign a_rise = st.sync[1] & ~st.prev[1];
	assign b_level = st.sync[0];
	// one phase changed but not both: a legal gray step; a double jump is dropped
	assign quad_step = (st.sync[1] ^ st.prev[1]) ^ (st.sync[0] ^ st.prev[0]);
	// phase b leading phase a counts up
	assign quad_up = st.prev[1] ^ st.sync[0];
endmodule : qpc_phase_decoder

//--- rtl/qpc_pkg.sv
// constants and field layout of the quadrature position counter
// ----------------------------------------------------------------
// Summary of operation
// - 32-bit read/write position count, zero after reset
// - count mode field picks the operating mode
// - quadrature mode decodes phases into pulses, direction
// - external mode: phase a counts, phase b direction
// - gated mode: phase a counts, b gates when enabled
// - timer mode counts divided bus clock ticks
// ----------------------------------------------------------------
package qpc_pkg;
	// register byte addresses
	localparam logic [7:0] OFS_POSITION = 8'h00;
	localparam logic [7:0] OFS_CONTROL = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam int ADDR_W = 8; // decoded address bits
	localparam int POS_W = 32; // position counter width
	localparam logic [31:0] POS_RESET = 32'h0000_0000;
	// encoder_control_register fields
	localparam int CTL_MODE_LSB = 0; // count_mode_select, 2 bits
	localparam int CTL_GATE_BIT = 2; // gate_enable_bit
	localparam int CTL_DIV_LSB = 4; // internal_clock_divider, 3 bits
	localparam int MODE_W = 2;
	localparam int DIV_W = 3;
	localparam int PRESC_W = 7; // holds up to 2^7 - 1
	// status register fields
	localparam int STA_DIR_BIT = 0; // last counted direction, 1 = up
	// count_mode_select codes
	localparam logic [1:0] MODE_QUAD = 2'h0;
	localparam logic [1:0] MODE_EXT_DIR = 2'h1;
	localparam logic [1:0] MODE_EXT_GATE = 2'h2;
	localparam logic [1:0] MODE_TIMER = 2'h3;
	localparam logic [1:0] CTL_MODE_RESET = 2'h0;
	localparam logic [2:0] CTL_DIV_RESET = 3'h0;
	// ahb-lite encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam int HTRANS_ACTIVE_BIT = 1;
endpackage : qpc_pkg

//--- rtl/qpc_top.sv
// quadrature position counter with ahb-lite register slave
`timescale 1ns/100ps
module qpc_top (
	// clocking
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// encoder pins
	input wire logic phase_a_input,
	input wire logic phase_b_input
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [qpc_pkg::POS_W-1:0] pos; // position_counter_register
		logic [qpc_pkg::MODE_W-1:0] mode; // count_mode_select
		logic gate_en; // gate_enable_bit
		logic [qpc_pkg::DIV_W-1:0] div; // internal_clock_divider
		logic [qpc_pkg::PRESC_W-1:0] presc; // timer prescaler
		logic last_up; // direction of last count
		logic dph_valid; // data phase pending
		logic dph_write; // pending transfer is a write
		logic [qpc_pkg::ADDR_W-1:0] dph_addr; // pending address
		logic [31:0] rdata; // read data register
	} qpc_state_t;

	qpc_state_t st; // registered state
	qpc_state_t next_st; // next state

	// decoder outputs
	logic a_rise;
	logic b_level;
	logic quad_step;
	logic quad_up;

	// count qualification
	logic cnt_pulse; // qualified count pulse
	logic cnt_up; // its direction
	logic tick; // prescaler terminal count
	logic addr_take; // address phase accepted

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	// terminal count of the prescaler, divide by two to the div
	function automatic logic [qpc_pkg::PRESC_W-1:0] qpc_div_last(
		input logic [qpc_pkg::DIV_W-1:0] d);
		logic [qpc_pkg::PRESC_W:0] one;
		one = {{qpc_pkg::PRESC_W{1'b0}}, 1'b1};
		qpc_div_last = qpc_pkg::PRESC_W'((one << d) - 1'b1);
	endfunction : qpc_div_last

	// register read mux, unmapped reads as zero
	function automatic logic [31:0] qpc_read(input qpc_state_t s,
		input logic [qpc_pkg::ADDR_W-1:0] a);
		qpc_read = '0;
		case (a)
			qpc_pkg::OFS_POSITION: begin
				qpc_read = s.pos;
			end
			qpc_pkg::OFS_CONTROL: begin
				qpc_read[qpc_pkg::CTL_MODE_LSB +: qpc_pkg::MODE_W] = s.mode;
				qpc_read[qpc_pkg::CTL_GATE_BIT] = s.gate_en;
				qpc_read[qpc_pkg::CTL_DIV_LSB +: qpc_pkg::DIV_W] = s.div;
			end
			qpc_pkg::OFS_STATUS: begin
				qpc_read[qpc_pkg::STA_DIR_BIT] = s.last_up;
			end
			default: begin
				qpc_read = '0;
			end
		endcase
	endfunction : qpc_read

	// ----------------------------------------------------------------
	// phase pins
	// ----------------------------------------------------------------
	qpc_phase_decoder u_dec (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.phase_a_input(phase_a_input),
		.phase_b_input(phase_b_input),
		.a_rise(a_rise),
		.b_level(b_level),
		.quad_step(quad_step),
		.quad_up(quad_up)
	);

	// ----------------------------------------------------------------
	// bus handshake
	// ----------------------------------------------------------------
	// no wait states, but a frozen block holds the bus off
	assign hreadyout = ce;
	assign hresp = 1'b0;
	assign hrdata = st.rdata;
	assign addr_take = hsel & hready & htrans[qpc_pkg::HTRANS_ACTIVE_BIT];

	// ----------------------------------------------------------------
	// count source selection
	// ----------------------------------------------------------------
	assign tick = (st.presc == qpc_div_last(st.div));

	// pick pulse and direction by mode
	always_comb begin
		cnt_pulse = 1'b0;
		cnt_up = 1'b1;
		case (st.mode)
			qpc_pkg::MODE_QUAD: begin
				cnt_pulse = quad_step;
				cnt_up = quad_up;
			end
			qpc_pkg::MODE_EXT_DIR: begin
				cnt_pulse = a_rise;
				cnt_up = b_level;
			end
			qpc_pkg::MODE_EXT_GATE: begin
				// gate low blocks pulses only when enabled
				cnt_pulse = a_rise & (~st.gate_en | b_level);
			end
			qpc_pkg::MODE_TIMER: begin
				cnt_pulse = tick;
			end
			default: begin
				cnt_pulse = 1'b0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_st = st;
		// prescaler runs only in timer mode so the first tick is a full period
		if (st.mode != qpc_pkg::MODE_TIMER || tick) begin
			next_st.presc = '0;
		end else begin
			next_st.presc = st.presc + 1'b1;
		end
		// counting, wraps naturally in 32 bits
		if (cnt_pulse) begin
			next_st.last_up = cnt_up;
			if (cnt_up) begin
				next_st.pos = st.pos + 1'b1;
			end else begin
				next_st.pos = st.pos - 1'b1;
			end
		end
		// data phase write; software write beats a count in the same cycle
		if (st.dph_valid && st.dph_write) begin
			case (st.dph_addr)
				qpc_pkg::OFS_POSITION: begin
					next_st.pos = hwdata;
				end
				qpc_pkg::OFS_CONTROL: begin
					next_st.mode = hwdata[qpc_pkg::CTL_MODE_LSB +: qpc_pkg::MODE_W];
					next_st.gate_en = hwdata[qpc_pkg::CTL_GATE_BIT];
					next_st.div = hwdata[qpc_pkg::CTL_DIV_LSB +: qpc_pkg::DIV_W];
					next_st.presc = '0;
				end
				default: begin
					// unmapped or read-only: ignored
				end
			endcase
		end
		// address phase
		next_st.dph_valid = addr_take;
		if (addr_take) begin
			next_st.dph_write = hwrite;
			next_st.dph_addr = haddr[qpc_pkg::ADDR_W-1:0];
			// read value sampled at address-phase edge
			next_st.rdata = hwrite ? st.rdata : qpc_read(st, haddr[qpc_pkg::ADDR_W-1:0]);
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
			st.pos <= qpc_pkg::POS_RESET;
			st.mode <= qpc_pkg::CTL_MODE_RESET;
			st.div <= qpc_pkg::CTL_DIV_RESET;
			st.last_up <= 1'b1;
		end else if (ce) begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	sequence s_pos_write;
		ce && st.dph_valid && st.dph_write && st.dph_addr == qpc_pkg::OFS_POSITION;
	endsequence

	sequence s_ctl_write;
		ce && st.dph_valid && st.dph_write && st.dph_addr == qpc_pkg::OFS_CONTROL;
	endsequence

	sequence s_free_count;
		ce && !(st.dph_valid && st.dph_write && st.dph_addr == qpc_pkg::OFS_POSITION);
	endsequence

	a_pos_write_lands: assert property (@(posedge clk) disable iff (!rst_n)
		s_pos_write |=> st.pos == $past(hwdata))
		else $error("position write not stored");

	a_mode_write_lands: assert property (@(posedge clk) disable iff (!rst_n)
		s_ctl_write |=> st.mode == $past(hwdata[1:0]) && st.gate_en == $past(hwdata[2]))
		else $error("control write not stored");

	a_quad_count_up: assert property (@(posedge clk) disable iff (!rst_n)
		s_free_count ##0 (st.mode == qpc_pkg::MODE_QUAD && quad_step && quad_up)
		|=> st.pos == $past(st.pos) + 32'h0000_0001)
		else $error("quadrature up step missed");

	a_ext_count_down: assert property (@(posedge clk) disable iff (!rst_n)
		s_free_count ##0 (st.mode == qpc_pkg::MODE_EXT_DIR && a_rise && !b_level)
		|=> st.pos == $past(st.pos) - 32'h0000_0001)
		else $error("external down count missed");

	a_gate_blocks: assert property (@(posedge clk) disable iff (!rst_n)
		s_free_count ##0 (st.mode == qpc_pkg::MODE_EXT_GATE && st.gate_en && !b_level)
		|=> $stable(st.pos))
		else $error("gated count leaked");

	a_timer_period: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && st.mode == qpc_pkg::MODE_TIMER && st.div == 3'h1 && st.presc == 7'h0
		&& !st.dph_valid) ##1 (ce && !st.dph_valid)
		|-> st.presc == 7'h1 ##1 (st.presc == 7'h0))
		else $error("timer prescaler period wrong");

	a_idle_holds: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && !cnt_pulse && !st.dph_valid) |=> $stable(st.pos))
		else $error("position moved without a pulse");

	a_freeze_all: assert property (@(posedge clk) disable iff (!rst_n)
		!ce |=> $stable(st) && $stable(hrdata))
		else $error("state changed while frozen");

	a_ready_okay: assert property (@(posedge clk) disable iff (!rst_n)
		hresp == 1'b0 && hreadyout == ce)
		else $error("bus answer wrong");
endmodule : qpc_top

//--- verif/qpc_encoder_model.sv
// stand-in encoder or external count source on the phase pins
`timescale 1ns/100ps
module qpc_encoder_model (
	// clocking
	input wire logic clk,
	// phase pins
	output logic phase_a_input,
	output logic phase_b_input
);
	int hold = 4; // cycles per level, 4 or more so each level is seen
	logic [1:0] q = 2'h0; // gray-code position of the shaft

	// ------------------------------------------------
	// pin stepping
	// ------------------------------------------------
	// quiet pins at time zero
	initial begin
		phase_a_input = 1'b0;
		phase_b_input = 1'b0;
	end

	// hold a level; shorter holds would slip past the sync flops
	task automatic settle();
		repeat (hold) @(posedge clk);
	endtask : settle

	// quadrature steps, b leads a when turning up, the decoder's up sense
	task automatic quad(input logic up, input int n);
		repeat (n) begin
			q = up ? q + 2'h1 : q - 2'h1;
			phase_a_input <= q[1];
			phase_b_input <= q[1] ^ q[0];
			settle();
		end
	endtask : quad

	// count pulses on phase a
	task automatic pulse(input int n);
		repeat (n) begin
			phase_a_input <= 1'b1;
			settle();
			phase_a_input <= 1'b0;
			settle();
		end
	endtask : pulse

	// direction or gate level on phase b
	task automatic set_b(input logic v);
		phase_b_input <= v;
		settle();
	endtask : set_b
endmodule : qpc_encoder_model

//--- verif/qpc_top_test.sv
// self-checking bench for the quadrature position counter
`timescale 1ns/100ps
module qpc_top_test;
	// ------------------------------------------------
	// wiring
	// ------------------------------------------------
	localparam logic [7:0] POS = qpc_pkg::OFS_POSITION;
	localparam logic [7:0] CTL = qpc_pkg::OFS_CONTROL;
	localparam logic [7:0] STA = qpc_pkg::OFS_STATUS;
	logic clk = 1'b0;
	logic rst_n;
	logic ce;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic phase_a_input;
	logic phase_b_input;
	int err_count = 0;
	int checked = 0;
	logic [31:0] rd;
	logic [31:0] r1;

	// 200 MHz clock
	always #2.5 clk = ~clk;

	qpc_top dut (.clk(clk), .rst_n(rst_n), .ce(ce), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.phase_a_input(phase_a_input), .phase_b_input(phase_b_input));
	qpc_encoder_model enc (.clk(clk), .phase_a_input(phase_a_input),
		.phase_b_input(phase_b_input));

	// ------------------------------------------------
	// bus and compare tasks
	// ------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// bounded wait for hready high at an edge
	task automatic wait_ready();
		int n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) err_count++;
	endtask : wait_ready

	// one single transfer, entered right after an edge
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= qpc_pkg::HTRANS_NONSEQ;
		hwrite <= wr;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
		q = hrdata;
	endtask : xfer

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, rd);
	endtask : wr

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0, rd);
		check(rd, exp);
	endtask : rdchk

	// verdict and end of run
	task automatic summarize();
		if (err_count == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : summarize

	// ------------------------------------------------
	// tests
	// ------------------------------------------------
	initial begin
		// bus idle and reset asserted from time zero
		rst_n <= 1'b0;
		ce <= 1'b1;
		hsel <= 1'b0;
		haddr <= 32'h0;
		htrans <= 2'h0;
		hwrite <= 1'b0;
		hsize <= 3'h2;
		hwdata <= 32'h0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rdchk(POS, 32'h0);
		rdchk(STA, 32'h1);
		rdchk(8'h0C, 32'h0);
		wr(POS, 32'hA5A5_5A5A);
		rdchk(POS, 32'hA5A5_5A5A);
		check({31'h0, hresp}, 32'h0);
		// quadrature, wrapping both ways; net steps keep pins at rest
		wr(POS, 32'hFFFF_FFFE);
		enc.quad(1'b1, 4);
		rdchk(POS, 32'h0000_0002);
		rdchk(STA, 32'h1);
		enc.hold = 7;
		enc.quad(1'b0, 8);
		rdchk(POS, 32'hFFFF_FFFA);
		rdchk(STA, 32'h0);
		enc.hold = 4;
		// external count, b gives direction
		wr(CTL, 32'h1);
		enc.set_b(1'b1);
		enc.pulse(3);
		rdchk(POS, 32'hFFFF_FFFD);
		enc.set_b(1'b0);
		enc.pulse(5);
		rdchk(POS, 32'hFFFF_FFF8);
		// gated count, gate off then on
		wr(CTL, 32'h2);
		enc.pulse(2);
		rdchk(POS, 32'hFFFF_FFFA);
		wr(CTL, 32'h6);
		rdchk(CTL, 32'h6);
		enc.pulse(2);
		rdchk(POS, 32'hFFFF_FFFA);
		enc.set_b(1'b1);
		enc.pulse(2);
		rdchk(POS, 32'hFFFF_FFFC);
		// timer: three divided periods between read address phases
		for (int d = 0; d < 8; d++) begin
			wr(CTL, 32'h3 + 32'(d << 4));
			xfer(1'b0, POS, 32'h0, r1);
			repeat ((3 << d) - 2) @(posedge clk);
			xfer(1'b0, POS, 32'h0, rd);
			check(rd - r1, 32'h3);
		end
		// clock enable low stalls the bus
		ce <= 1'b0;
		repeat (2) @(posedge clk);
		check({31'h0, hreadyout}, 32'h0);
		ce <= 1'b1;
		@(posedge clk);
		summarize();
	end

	// watchdog, well past the thousand or so cycles the tests need
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		summarize();
	end
endmodule : qpc_top_test
